// *** pkg/s4rx_pkg.sv ***
// Shared constants and types for the wide receive buffer read port
package s4rx_pkg;
	// Data path
	localparam int DATA_W = 64;
	localparam int LANES = DATA_W / 8;
	localparam int PORT_W = 8;
	// Virtual FIFO layout: two merged memories, two FIFOs each
	localparam int SEL_W = 2;
	localparam int NUM_MEMS = 2;
	localparam int FIFOS_PER_MEM = 2;
	localparam int FIFO_DEPTH = 64;
	// Low-fill mark: seven two-word bursts left
	localparam int BURST_WORDS = 2;
	localparam int LOW_BURSTS = 7;
	localparam int LOW_MARK_WORDS = LOW_BURSTS * BURST_WORDS;
	// Timing
	localparam int READ_LATENCY = 2;
	localparam int PAUSE_CYCLES = 2;
	// Byte lane patterns
	localparam logic [LANES-1:0] ID_LANES = 8'h01;
	localparam logic [LANES-1:0] FULL_LANES = 8'hFF;
	localparam logic [LANES-1:0] IDLE_LANES = 8'h00;
	// Stored entry layout
	localparam int E_DATA_LSB = 0;
	localparam int E_LANES_LSB = E_DATA_LSB + DATA_W;
	localparam int E_SOP = E_LANES_LSB + LANES;
	localparam int E_EOP = E_SOP + 1;
	localparam int E_ERR = E_EOP + 1;
	localparam int E_PORT_LSB = E_ERR + 1;
	localparam int ENTRY_W = E_PORT_LSB + PORT_W;
	// Output word position inside a burst
	localparam logic [1:0] IDX_NONE = 2'h0;
	localparam logic [1:0] IDX_FIRST = 2'h1;
	localparam logic [1:0] IDX_SECOND = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_W0, ST_W1, ST_PAUSE} s4rx_state_t;
endpackage : s4rx_pkg

// *** rtl/s4rx_wide_bank.sv ***
// One merged buffer memory holding several virtual FIFOs
`timescale 1ns/1ns
module s4rx_wide_bank import s4rx_pkg::*; #(
	parameter int FIFOS = FIFOS_PER_MEM,
	parameter int DEPTH = FIFO_DEPTH,
	parameter int EW = ENTRY_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Fill side
	input wire logic push,
	input wire logic [$clog2(FIFOS)-1:0] push_fifo,
	input wire logic [EW-1:0] push_entry,
	output logic push_ready,
	// Read side
	input wire logic pop,
	input wire logic [$clog2(FIFOS)-1:0] rd_fifo,
	output logic [EW-1:0] head_entry,
	output logic head_valid,
	// Poll side
	input wire logic [$clog2(FIFOS)-1:0] poll_fifo,
	output logic poll_low
);
	localparam int IW = $clog2(FIFOS);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	logic [EW-1:0] mem [FIFOS*DEPTH];
	logic [AW-1:0] wp_r [FIFOS];
	logic [AW-1:0] rp_r [FIFOS];
	logic [CW-1:0] cnt_r [FIFOS];
	wire logic do_push;
	wire logic do_pop;

	assign push_ready = cnt_r[push_fifo] != CW'(DEPTH);
	assign head_valid = cnt_r[rd_fifo] != '0;
	assign head_entry = mem[{rd_fifo, rp_r[rd_fifo]}];
	assign poll_low = cnt_r[poll_fifo] <= CW'(LOW_MARK_WORDS);
	assign do_push = push && push_ready;
	assign do_pop = pop && head_valid;

	// Storage has no reset; pointers guard it
	always_ff @(posedge ref_clk) begin
		if (do_push)
			mem[{push_fifo, wp_r[push_fifo]}] <= push_entry;
	end

	logic [FIFOS-1:0] inc_v;
	logic [FIFOS-1:0] dec_v;

	for (genvar f = 0; f < FIFOS; f++) begin : g_ptr
		assign inc_v[f] = do_push && push_fifo == IW'(f);
		assign dec_v[f] = do_pop && rd_fifo == IW'(f);
	end

	// One process owns all pointer arrays
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int f = 0; f < FIFOS; f++) begin
				wp_r[f] <= '0;
				rp_r[f] <= '0;
				cnt_r[f] <= '0;
			end
		end else begin
			for (int f = 0; f < FIFOS; f++) begin
				if (inc_v[f])
					wp_r[f] <= wp_r[f] + AW'(1);
				if (dec_v[f])
					rp_r[f] <= rp_r[f] + AW'(1);
				cnt_r[f] <= cnt_r[f] + CW'(inc_v[f]) - CW'(dec_v[f]);
			end
		end
	end
endmodule : s4rx_wide_bank

// *** rtl/s4rx_wide_port.sv ***
// Wide receive buffer read port, 64-bit aggregation mode
`timescale 1ns/1ns
module s4rx_wide_port import s4rx_pkg::*; #(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Fill side from the line receiver
	input wire logic fill_valid,
	output logic fill_ready,
	input wire logic [SEL_W-1:0] fill_fifo,
	input wire logic [DATA_W-1:0] fill_data,
	input wire logic [LANES-1:0] fill_lanes,
	input wire logic fill_sop,
	input wire logic fill_eop,
	input wire logic fill_err,
	input wire logic [PORT_W-1:0] fill_port_id,
	// User read request
	input wire logic wide_read_strobe,
	input wire logic [SEL_W-1:0] wide_fifo_select,
	input wire logic pause_after_packet_end,
	// User read data
	output logic [DATA_W-1:0] wide_read_data,
	output logic [LANES-1:0] wide_byte_valid_lanes,
	output logic tag_word_flag,
	output logic packet_start_flag,
	output logic packet_end_flag,
	output logic packet_error_flag,
	output logic low_fill_flag
);
	localparam int IW = SEL_W - 1;

	s4rx_state_t state_r, state_nxt;
	logic req_pend_r, req_pend_nxt;
	logic [SEL_W-1:0] req_sel_r, req_sel_nxt;
	logic [SEL_W-1:0] cur_sel_r, cur_sel_nxt;
	logic [PORT_W-1:0] last_port_r, last_port_nxt;
	logic last_ok_r, last_ok_nxt;
	logic [1:0] pause_cnt_r, pause_cnt_nxt;
	logic [1:0] out_idx_r, out_idx_nxt;
	logic [DATA_W-1:0] data_nxt;
	logic [LANES-1:0] lanes_nxt;
	logic tag_nxt, sop_nxt, eop_nxt, err_nxt;
	logic take, emit, first, pop_w;

	logic [NUM_MEMS-1:0] push_v, rdy_v, pop_v, hv_v, low_v;
	logic [ENTRY_W-1:0] head_v [NUM_MEMS];
	wire logic [ENTRY_W-1:0] fill_entry;
	wire logic [SEL_W-1:0] rd_sel_w;
	wire logic [ENTRY_W-1:0] head_w;
	wire logic head_ok_w;
	wire logic [PORT_W-1:0] h_port;
	wire logic h_eop;
	wire logic need_id_w;
	wire logic sel_low_w;

	assign fill_entry = {fill_port_id, fill_err, fill_eop, fill_sop, fill_lanes, fill_data};
	assign fill_ready = rdy_v[fill_fifo[SEL_W-1]];

	// Each merged memory holds two virtual FIFOs, each with its own pointer set
	for (genvar m = 0; m < NUM_MEMS; m++) begin : g_mem
		assign push_v[m] = fill_valid && fill_fifo[SEL_W-1] == 1'(m);
		assign pop_v[m] = pop_w && rd_sel_w[SEL_W-1] == 1'(m);
		s4rx_wide_bank #(.FIFOS(FIFOS_PER_MEM), .DEPTH(DEPTH), .EW(ENTRY_W)) u_bank (
			.ref_clk(ref_clk),
			.rst(rst),
			.push(push_v[m]),
			.push_fifo(fill_fifo[IW-1:0]),
			.push_entry(fill_entry),
			.push_ready(rdy_v[m]),
			.pop(pop_v[m]),
			.rd_fifo(rd_sel_w[IW-1:0]),
			.head_entry(head_v[m]),
			.head_valid(hv_v[m]),
			.poll_fifo(wide_fifo_select[IW-1:0]),
			.poll_low(low_v[m])
		);
	end

	// Idle reads the pending request's buffer, a burst keeps its own
	assign rd_sel_w = (state_r == ST_IDLE) ? req_sel_r : cur_sel_r;
	assign head_w = head_v[rd_sel_w[SEL_W-1]];
	assign head_ok_w = hv_v[rd_sel_w[SEL_W-1]];
	assign h_port = head_w[E_PORT_LSB +: PORT_W];
	assign h_eop = head_w[E_EOP];
	assign need_id_w = !last_ok_r || h_port != last_port_r;
	assign sel_low_w = low_v[wide_fifo_select[SEL_W-1]];

	// A new strobe wins over the consume of the old one
	assign req_pend_nxt = wide_read_strobe ? 1'b1 : (take ? 1'b0 : req_pend_r);
	assign req_sel_nxt = wide_read_strobe ? wide_fifo_select : req_sel_r;

	always_comb begin
		state_nxt = state_r;
		cur_sel_nxt = cur_sel_r;
		last_port_nxt = last_port_r;
		last_ok_nxt = last_ok_r;
		pause_cnt_nxt = pause_cnt_r;
		data_nxt = wide_read_data;
		lanes_nxt = IDLE_LANES;
		tag_nxt = 1'b0;
		sop_nxt = 1'b0;
		eop_nxt = 1'b0;
		err_nxt = 1'b0;
		out_idx_nxt = IDX_NONE;
		take = 1'b0;
		emit = 1'b0;
		first = 1'b0;
		pop_w = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				if (req_pend_r) begin
					take = 1'b1;
					cur_sel_nxt = req_sel_r;
					if (head_ok_w && need_id_w) begin
						data_nxt = {{(DATA_W-PORT_W){1'b0}}, h_port};
						lanes_nxt = ID_LANES;
						tag_nxt = 1'b1;
						last_port_nxt = h_port;
						last_ok_nxt = 1'b1;
						state_nxt = ST_W0;
					end else begin
						emit = 1'b1;
						first = 1'b1;
					end
				end
			end
			ST_W0: begin
				emit = 1'b1;
				first = 1'b1;
			end
			ST_W1: emit = 1'b1;
			ST_PAUSE: begin
				if (pause_cnt_r == 2'h0)
					state_nxt = ST_IDLE;
				else
					pause_cnt_nxt = pause_cnt_r - 2'h1;
			end
		endcase
		// An empty buffer ends the burst with an idle word
		if (emit) begin
			state_nxt = ST_IDLE;
			if (head_ok_w) begin
				pop_w = 1'b1;
				data_nxt = head_w[E_DATA_LSB +: DATA_W];
				lanes_nxt = h_eop ? head_w[E_LANES_LSB +: LANES] : FULL_LANES;
				sop_nxt = head_w[E_SOP];
				eop_nxt = h_eop;
				err_nxt = head_w[E_ERR];
				out_idx_nxt = first ? IDX_FIRST : IDX_SECOND;
				if (h_eop && pause_after_packet_end) begin
					state_nxt = ST_PAUSE;
					pause_cnt_nxt = 2'(PAUSE_CYCLES - 1);
				end else if (first && !h_eop) begin
					state_nxt = ST_W1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			req_pend_r <= 1'b0;
			req_sel_r <= '0;
			cur_sel_r <= '0;
			last_port_r <= '0;
			last_ok_r <= 1'b0;
			pause_cnt_r <= 2'h0;
			out_idx_r <= IDX_NONE;
		end else begin
			state_r <= state_nxt;
			req_pend_r <= req_pend_nxt;
			req_sel_r <= req_sel_nxt;
			cur_sel_r <= cur_sel_nxt;
			last_port_r <= last_port_nxt;
			last_ok_r <= last_ok_nxt;
			pause_cnt_r <= pause_cnt_nxt;
			out_idx_r <= out_idx_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wide_read_data <= '0;
			wide_byte_valid_lanes <= IDLE_LANES;
			tag_word_flag <= 1'b0;
			packet_start_flag <= 1'b0;
			packet_end_flag <= 1'b0;
			packet_error_flag <= 1'b0;
			low_fill_flag <= 1'b0;
		end else begin
			wide_read_data <= data_nxt;
			wide_byte_valid_lanes <= lanes_nxt;
			tag_word_flag <= tag_nxt;
			packet_start_flag <= sop_nxt;
			packet_end_flag <= eop_nxt;
			packet_error_flag <= err_nxt;
			low_fill_flag <= sel_low_w;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_strobe_taken;
		wide_read_strobe && state_r == ST_IDLE && !req_pend_r
		##1 req_pend_r && state_r == ST_IDLE && head_ok_w;
	endsequence
	sequence s_pause_end;
		packet_end_flag && out_idx_r != IDX_NONE && $past(pause_after_packet_end);
	endsequence

	AST_LATENCY: assert property (s_strobe_taken |=> tag_word_flag || out_idx_r == IDX_FIRST)
		else $error("read word not presented two cycles after strobe");
	AST_ID_LANES: assert property (tag_word_flag |-> wide_byte_valid_lanes == ID_LANES)
		else $error("identifier word with wrong byte lanes");
	AST_ID_NEW: assert property (tag_word_flag |-> !$past(last_ok_r)
		|| $past(last_port_r) != wide_read_data[PORT_W-1:0])
		else $error("identifier word for unchanged port");
	AST_BURST_LEN: assert property (out_idx_r == IDX_SECOND |=> out_idx_r != IDX_SECOND)
		else $error("burst longer than two data words");
	AST_CUT: assert property (packet_end_flag && out_idx_r == IDX_FIRST |=> out_idx_r != IDX_SECOND)
		else $error("burst continued after packet end");
	AST_FULL_LANES: assert property (out_idx_r != IDX_NONE && !packet_end_flag
		|-> wide_byte_valid_lanes == FULL_LANES)
		else $error("full data word without all lanes");
	AST_PAUSE: assert property (s_pause_end |=> (wide_byte_valid_lanes == IDLE_LANES) [*2])
		else $error("idle cycles missing after packet end");
	AST_ERR_DATA: assert property (packet_error_flag |-> out_idx_r != IDX_NONE)
		else $error("error flag outside a data word");
	AST_MERGE: assert property ($onehot0(pop_v) && (!pop_w || head_ok_w))
		else $error("read from both merged memories at once");
	AST_LOW_FILL: assert property (!$past(rst) |-> low_fill_flag == $past(sel_low_w))
		else $error("low-fill flag does not follow the select");
endmodule : s4rx_wide_port

// *** sim/s4rx_user_reader.sv ***
// User-side reader model issuing read strobes and FIFO selects
`timescale 1ns/1ns
module s4rx_user_reader import s4rx_pkg::*; (
	// Requests from the bench
	input wire logic go,
	input wire logic [SEL_W-1:0] go_sel,
	// Toward the read port
	output logic wide_read_strobe,
	output logic [SEL_W-1:0] wide_fifo_select
);
	// Strobe and select change together; select stays for polling
	assign wide_read_strobe = go;
	assign wide_fifo_select = go_sel;
endmodule : s4rx_user_reader

// *** sim/spi4_rx_wide_fifo_read_port_bench.sv ***
// Self-checking bench for the wide receive read port
`timescale 1ns/1ns
module spi4_rx_wide_fifo_read_port_bench import s4rx_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic fill_valid = 1'b0;
	logic fill_ready;
	logic [SEL_W-1:0] fill_fifo = 2'h0;
	logic [DATA_W-1:0] fill_data = 64'h0;
	logic [LANES-1:0] fill_lanes = 8'h00;
	logic fill_sop = 1'b0;
	logic fill_eop = 1'b0;
	logic fill_err = 1'b0;
	logic [PORT_W-1:0] fill_port_id = 8'h00;
	logic go = 1'b0;
	logic [SEL_W-1:0] go_sel = 2'h0;
	logic pause_after_packet_end = 1'b0;
	logic wide_read_strobe;
	logic [SEL_W-1:0] wide_fifo_select;
	logic [DATA_W-1:0] wide_read_data;
	logic [LANES-1:0] wide_byte_valid_lanes;
	logic tag_word_flag;
	logic packet_start_flag;
	logic packet_end_flag;
	logic packet_error_flag;
	logic low_fill_flag;
	int err_total = 0;
	int tests_run = 0;

	s4rx_wide_port #(.DEPTH(FIFO_DEPTH)) s4rx_wide_port_inst (.ref_clk(ref_clk), .rst(rst),
		.fill_valid(fill_valid), .fill_ready(fill_ready), .fill_fifo(fill_fifo),
		.fill_data(fill_data), .fill_lanes(fill_lanes), .fill_sop(fill_sop),
		.fill_eop(fill_eop), .fill_err(fill_err), .fill_port_id(fill_port_id),
		.wide_read_strobe(wide_read_strobe), .wide_fifo_select(wide_fifo_select),
		.pause_after_packet_end(pause_after_packet_end), .wide_read_data(wide_read_data),
		.wide_byte_valid_lanes(wide_byte_valid_lanes), .tag_word_flag(tag_word_flag),
		.packet_start_flag(packet_start_flag), .packet_end_flag(packet_end_flag),
		.packet_error_flag(packet_error_flag), .low_fill_flag(low_fill_flag));

	s4rx_user_reader s4rx_user_reader_inst (.go(go), .go_sel(go_sel),
		.wide_read_strobe(wide_read_strobe), .wide_fifo_select(wide_fifo_select));

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic push(input logic [1:0] f, input logic [63:0] d, input logic [7:0] l,
		input logic s, input logic e, input logic r, input logic [7:0] p);
		@(negedge ref_clk);
		fill_valid = 1'b1;
		fill_fifo = f;
		fill_data = d;
		fill_lanes = l;
		{fill_sop, fill_eop, fill_err} = {s, e, r};
		fill_port_id = p;
		@(posedge ref_clk);
	endtask : push

	task automatic fill_stop();
		@(negedge ref_clk);
		fill_valid = 1'b0;
	endtask : fill_stop

	// Strobe for one cycle, return in the cycle before the first answer
	task automatic rd(input logic [1:0] s);
		@(negedge ref_clk);
		go = 1'b1;
		go_sel = s;
		@(negedge ref_clk);
		go = 1'b0;
	endtask : rd

	// Flags are tag, start, end, error; only the low byte counts on a tag word
	task automatic ow(input logic [63:0] d, input logic [7:0] l, input logic [3:0] f);
		logic [63:0] m;
		@(negedge ref_clk);
		m = (l == ID_LANES) ? 64'h0000_0000_0000_00FF : 64'hFFFF_FFFF_FFFF_FFFF;
		chk({56'h0, wide_byte_valid_lanes}, {56'h0, l});
		if (l != IDLE_LANES) begin
			chk(wide_read_data & m, d & m);
			chk({60'h0, tag_word_flag, packet_start_flag, packet_end_flag,
				packet_error_flag}, {60'h0, f});
		end
	endtask : ow

	task automatic t_reset();
		@(negedge ref_clk);
		chk(wide_read_data, 64'h0);
		chk({56'h0, wide_byte_valid_lanes}, {56'h0, IDLE_LANES});
		chk({60'h0, tag_word_flag, packet_start_flag, packet_end_flag, packet_error_flag}, 64'h0);
		rst = 1'b0;
		@(negedge ref_clk);
		chk({63'h0, low_fill_flag}, 64'h1);
		chk({63'h0, fill_ready}, 64'h1);
	endtask : t_reset

	// Three-word packet: id, full burst, then a burst cut at the end word
	task automatic t_packet();
		push(2'h0, 64'h1111_2222_3333_4444, 8'hFF, 1'b1, 1'b0, 1'b0, 8'h5A);
		push(2'h0, 64'h5555_6666_7777_8888, 8'hFF, 1'b0, 1'b0, 1'b1, 8'h5A);
		push(2'h0, 64'h9999_AAAA_BBBB_CCCC, 8'h0F, 1'b0, 1'b1, 1'b1, 8'h5A);
		push(2'h0, 64'h1234_5678_9ABC_DEF0, 8'h07, 1'b1, 1'b1, 1'b0, 8'h5A);
		fill_stop();
		rd(2'h0);
		ow(64'h5A, ID_LANES, 4'h8);
		ow(64'h1111_2222_3333_4444, FULL_LANES, 4'h4);
		ow(64'h5555_6666_7777_8888, FULL_LANES, 4'h1);
		ow(64'h0, IDLE_LANES, 4'h0);
		rd(2'h0);
		ow(64'h9999_AAAA_BBBB_CCCC, 8'h0F, 4'h3);
		ow(64'h0, IDLE_LANES, 4'h0);
		rd(2'h0);
		ow(64'h1234_5678_9ABC_DEF0, 8'h07, 4'h6);
		ow(64'h0, IDLE_LANES, 4'h0);
	endtask : t_packet

	// Second merged memory, new port, pause after the end word
	task automatic t_pause();
		push(2'h2, 64'hDEAD_0000_BEEF_0001, 8'h03, 1'b1, 1'b1, 1'b0, 8'h33);
		push(2'h3, 64'h0BAD_F00D_0000_0007, 8'h07, 1'b1, 1'b1, 1'b0, 8'h33);
		fill_stop();
		pause_after_packet_end = 1'b1;
		rd(2'h2);
		ow(64'h33, ID_LANES, 4'h8);
		// Next buffer asked for during the last burst; pause must hold it back
		go = 1'b1;
		go_sel = 2'h3;
		ow(64'hDEAD_0000_BEEF_0001, 8'h03, 4'h6);
		go = 1'b0;
		ow(64'h0, IDLE_LANES, 4'h0);
		ow(64'h0, IDLE_LANES, 4'h0);
		ow(64'h0BAD_F00D_0000_0007, 8'h07, 4'h6);
		ow(64'h0, IDLE_LANES, 4'h0);
		pause_after_packet_end = 1'b0;
	endtask : t_pause

	// Low-fill mark sits at fourteen words
	task automatic t_poll();
		for (int i = 0; i <= LOW_MARK_WORDS; i++) begin
			push(2'h1, 64'h0 | i, FULL_LANES, i == 0, 1'b0, 1'b0, 8'h33);
		end
		fill_stop();
		go_sel = 2'h1;
		@(negedge ref_clk);
		chk({63'h0, low_fill_flag}, 64'h0);
		rd(2'h1);
		ow(64'h0, FULL_LANES, 4'h4);
		chk({63'h0, low_fill_flag}, 64'h0);
		ow(64'h1, FULL_LANES, 4'h0);
		chk({63'h0, low_fill_flag}, 64'h1);
		@(negedge ref_clk);
		chk({63'h0, low_fill_flag}, 64'h1);
	endtask : t_poll

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (8) @(posedge ref_clk);
		t_reset();
		t_packet();
		t_pause();
		t_poll();
		repeat (4) @(negedge ref_clk);
		give_verdict();
	end

	// Tests need well under a thousand cycles
	initial begin
		#50000;
		err_total++;
		give_verdict();
	end
endmodule : spi4_rx_wide_fifo_read_port_bench
